// *** rrio_core.sv ***
// remote dedicated i/o block: line mapping, slot control, wishbone registers
//
// The placing of the registers and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
`include "rrio_params.svh"
module rrio_core (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [31:0] din,
  output logic [31:0] dout,
  output logic servo_power,
  output logic irq
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [1:0] mode_reg, mode_next;
  logic servo_req_reg, servo_req_next;
  rrio_pkg::rrio_state_e state_reg, state_next;
  logic err_reg, err_next;
  logic cyc_reg, cyc_next;
  logic ready_reg, ready_next;
  logic [15:0] rdy_cnt_reg, rdy_cnt_next;
  logic [`RRIO_NIRQ-1:0] ist_reg, ist_next;
  logic [`RRIO_NIRQ-1:0] imask_reg, imask_next;
  logic [4:0] map_in_reg [`RRIO_NFUNC];
  logic [4:0] map_in_next [`RRIO_NFUNC];
  logic [4:0] map_out_reg [`RRIO_NFUNC];
  logic [4:0] map_out_next [`RRIO_NFUNC];
  logic ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  logic [31:0] dout_reg, dout_next;
  logic servo_reg, servo_next;

  logic [`RRIO_NFUNC-1:0] in_level;
  logic [`RRIO_NFUNC-1:0] in_rise;
  logic [`RRIO_NFUNC-1:0] fval;
  logic acc, wr, rd;
  logic [3:0] map_idx;
  logic map_hit;
  logic [`RRIO_NIRQ-1:0] ev;
  logic stop_any, allow_ok, start_ok;

  // ---------------------------------------------------------------
  // input stages, one per input function
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `RRIO_NFUNC; gi++) begin : g_in
      if (gi >= `RRIO_FIRST_IN) begin : g_used
        rrio_in_stage u_stage (
          .ref_clk(ref_clk),
          .nrst(nrst),
          .lines(din),
          .sel(map_in_reg[gi]),
          .level(in_level[gi]),
          .rise(in_rise[gi])
        );
      end else begin : g_none
        assign in_level[gi] = 1'b0;
        assign in_rise[gi] = 1'b0;
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  // write lands on the edge that ends ack, matching classic handshake
  assign acc = wb_cyc_i & wb_stb_i & ack_reg;
  assign wr = acc & wb_we_i;
  assign rd = wb_cyc_i & wb_stb_i & ~ack_reg & ~wb_we_i;
  assign map_hit = (wb_adr_i >= `RRIO_MAP_BASE) &&
                   (wb_adr_i < (`RRIO_MAP_BASE + 8'(4 * `RRIO_NFUNC))) && (wb_adr_i[1:0] == 2'b00);
  assign map_idx = 4'((wb_adr_i - `RRIO_MAP_BASE) >> 2);

  // ---------------------------------------------------------------
  // slot control terms
  // ---------------------------------------------------------------
  always_comb begin
    stop_any = in_level[rrio_pkg::RRIO_F_STOP] | in_level[rrio_pkg::RRIO_F_HALT2];
    allow_ok = in_level[rrio_pkg::RRIO_F_ALLOW] & ready_reg;
    // external start only counts in remote mode with power-on done
    start_ok = in_rise[rrio_pkg::RRIO_F_START] & allow_ok & ~stop_any & ~err_reg &
               (mode_reg == rrio_pkg::RRIO_MODE_REMOTE) & servo_reg;
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    mode_next = mode_reg;
    servo_req_next = servo_req_reg;
    state_next = state_reg;
    err_next = err_reg;
    cyc_next = cyc_reg;
    ready_next = ready_reg;
    rdy_cnt_next = rdy_cnt_reg;
    imask_next = imask_reg;
    ev = '0;
    for (int i = 0; i < `RRIO_NFUNC; i++) begin
      map_in_next[i] = map_in_reg[i];
      map_out_next[i] = map_out_reg[i];
    end

    if (!ready_reg) begin
      if (rdy_cnt_reg == 16'(`RRIO_READY_CYC - 1)) begin
        ready_next = 1'b1;
      end else begin
        rdy_cnt_next = rdy_cnt_reg + 16'h0001;
      end
    end

    unique case (state_reg)
      rrio_pkg::RRIO_ST_IDLE: begin
        if (start_ok) begin
          state_next = rrio_pkg::RRIO_ST_RUN;
          ev[`RRIO_IRQ_START] = 1'b1;
        end
      end
      rrio_pkg::RRIO_ST_RUN: begin
        if (stop_any || err_reg || !servo_reg) begin
          state_next = rrio_pkg::RRIO_ST_WAIT;
          ev[`RRIO_IRQ_WAIT] = 1'b1;
        end else if (wr && wb_adr_i == `RRIO_CMD_OFS && wb_sel_i[0] && wb_dat_i[`RRIO_CMD_END_BIT]) begin
          // end of program: a pending cycle stop completes here
          state_next = rrio_pkg::RRIO_ST_IDLE;
          if (cyc_reg) begin
            ev[`RRIO_IRQ_CYCLE_DONE] = 1'b1;
          end
          cyc_next = 1'b0;
        end
        if (in_rise[rrio_pkg::RRIO_F_CYCLE]) begin
          cyc_next = 1'b1;
        end
      end
      rrio_pkg::RRIO_ST_WAIT: begin
        if (in_rise[rrio_pkg::RRIO_F_PRGRST]) begin
          state_next = rrio_pkg::RRIO_ST_IDLE;
          cyc_next = 1'b0;
          ev[`RRIO_IRQ_PRG_RESET] = 1'b1;
        end else if (start_ok) begin
          state_next = rrio_pkg::RRIO_ST_RUN;
          ev[`RRIO_IRQ_START] = 1'b1;
        end
      end
      default: state_next = rrio_pkg::RRIO_ST_IDLE;
    endcase

    // set wins over the fault clear edge
    if (in_rise[rrio_pkg::RRIO_F_FLTCLR]) begin
      err_next = 1'b0;
    end
    if (wr && wb_adr_i == `RRIO_CMD_OFS && wb_sel_i[0] && wb_dat_i[`RRIO_CMD_ERR_BIT]) begin
      err_next = 1'b1;
      ev[`RRIO_IRQ_ERROR] = 1'b1;
    end

    if (wr && wb_adr_i == `RRIO_CTRL_OFS && wb_sel_i[0]) begin
      mode_next = wb_dat_i[`RRIO_CTRL_MODE_LSB +: 2];
      servo_req_next = wb_dat_i[`RRIO_CTRL_SERVO_BIT];
    end
    if (wr && wb_adr_i == `RRIO_IRQ_MASK_OFS && wb_sel_i[0]) begin
      imask_next = wb_dat_i[`RRIO_NIRQ-1:0];
    end
    if (wr && map_hit) begin
      // the fixed stop function keeps input line 0
      if (wb_sel_i[0] && map_idx >= 4'(`RRIO_FIRST_IN) && map_idx != rrio_pkg::RRIO_F_STOP) begin
        map_in_next[map_idx] = wb_dat_i[`RRIO_MAP_IN_LSB +: 5];
      end
      if (wb_sel_i[1]) begin
        map_out_next[map_idx] = wb_dat_i[`RRIO_MAP_OUT_LSB +: 5];
      end
    end

    // write-one-to-clear; a fresh event in the same cycle stays set
    ist_next = ist_reg;
    if (wr && wb_adr_i == `RRIO_IRQ_STAT_OFS && wb_sel_i[0]) begin
      ist_next = ist_reg & ~wb_dat_i[`RRIO_NIRQ-1:0];
    end
    ist_next = ist_next | ev;

    // servo follows software request unless held off by the input
    servo_next = servo_req_next & ~in_level[rrio_pkg::RRIO_F_SERVO_DISABLE_REQ];
  end

  // ---------------------------------------------------------------
  // status values and output line mapping
  // ---------------------------------------------------------------
  always_comb begin
    fval[rrio_pkg::RRIO_F_TEACH] = ready_reg & (mode_reg == rrio_pkg::RRIO_MODE_TEACH);
    fval[rrio_pkg::RRIO_F_AUTO] = ready_reg & (mode_reg == rrio_pkg::RRIO_MODE_AUTO);
    fval[rrio_pkg::RRIO_F_REMOTE] = ready_reg & (mode_reg == rrio_pkg::RRIO_MODE_REMOTE);
    fval[rrio_pkg::RRIO_F_READY] = ready_reg;
    fval[rrio_pkg::RRIO_F_STOP] = (state_reg == rrio_pkg::RRIO_ST_WAIT);
    fval[rrio_pkg::RRIO_F_ALLOW] = allow_ok;
    fval[rrio_pkg::RRIO_F_START] = (state_reg == rrio_pkg::RRIO_ST_RUN);
    fval[rrio_pkg::RRIO_F_HALT2] = (state_reg == rrio_pkg::RRIO_ST_WAIT);
    fval[rrio_pkg::RRIO_F_PRGRST] = ready_reg & (state_reg == rrio_pkg::RRIO_ST_IDLE);
    fval[rrio_pkg::RRIO_F_FLTCLR] = err_reg;
    fval[rrio_pkg::RRIO_F_CYCLE] = cyc_reg;
    fval[rrio_pkg::RRIO_F_SERVO_DISABLE_REQ] = ready_reg & ~in_level[rrio_pkg::RRIO_F_SERVO_DISABLE_REQ];
  end

  genvar gl;
  generate
    for (gl = 0; gl < `RRIO_LINES; gl++) begin : g_out
      always_comb begin
        dout_next[gl] = 1'b0;
        for (int f = 0; f < `RRIO_NFUNC; f++) begin
          if (map_out_reg[f] == 5'(gl) && fval[f]) begin
            dout_next[gl] = 1'b1;
          end
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // bus answer
  // ---------------------------------------------------------------
  always_comb begin
    ack_next = wb_cyc_i & wb_stb_i & ~ack_reg;
    rdat_next = rdat_reg;
    if (rd) begin
      rdat_next = 32'h0000_0000;
      if (map_hit) begin
        rdat_next[`RRIO_MAP_IN_LSB +: 5] = map_in_reg[map_idx];
        rdat_next[`RRIO_MAP_OUT_LSB +: 5] = map_out_reg[map_idx];
      end else begin
        unique case (wb_adr_i)
          `RRIO_CTRL_OFS: begin
            rdat_next[`RRIO_CTRL_MODE_LSB +: 2] = mode_reg;
            rdat_next[`RRIO_CTRL_SERVO_BIT] = servo_req_reg;
          end
          `RRIO_STATUS_OFS: begin
            rdat_next[1:0] = state_reg;
            rdat_next[2] = err_reg;
            rdat_next[3] = cyc_reg;
            rdat_next[4] = ready_reg;
            rdat_next[5] = servo_reg;
            rdat_next[6] = allow_ok;
          end
          `RRIO_IRQ_STAT_OFS: rdat_next[`RRIO_NIRQ-1:0] = ist_reg;
          `RRIO_IRQ_MASK_OFS: rdat_next[`RRIO_NIRQ-1:0] = imask_reg;
          `RRIO_LINES_OFS: rdat_next = din;
          default: rdat_next = 32'h0000_0000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      mode_reg <= 2'h0;
      servo_req_reg <= 1'b0;
      state_reg <= rrio_pkg::RRIO_ST_IDLE;
      err_reg <= 1'b0;
      cyc_reg <= 1'b0;
      ready_reg <= 1'b0;
      rdy_cnt_reg <= 16'h0000;
      ist_reg <= '0;
      imask_reg <= '0;
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
      dout_reg <= 32'h0000_0000;
      servo_reg <= 1'b0;
      for (int i = 0; i < `RRIO_NFUNC; i++) begin
        map_in_reg[i] <= (i >= `RRIO_FIRST_IN) ? 5'(i - `RRIO_FIRST_IN) : 5'h00;
        map_out_reg[i] <= 5'(i);
      end
    end else begin
      mode_reg <= mode_next;
      servo_req_reg <= servo_req_next;
      state_reg <= state_next;
      err_reg <= err_next;
      cyc_reg <= cyc_next;
      ready_reg <= ready_next;
      rdy_cnt_reg <= rdy_cnt_next;
      ist_reg <= ist_next;
      imask_reg <= imask_next;
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
      dout_reg <= dout_next;
      servo_reg <= servo_next;
      for (int i = 0; i < `RRIO_NFUNC; i++) begin
        map_in_reg[i] <= map_in_next[i];
        map_out_reg[i] <= map_out_next[i];
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;
  assign dout = dout_reg;
  assign servo_power = servo_reg;
  assign irq = |(ist_reg & imask_reg);

endmodule

// *** rrio_params.svh ***
// constants for the remote dedicated i/o block
`ifndef RRIO_PARAMS_SVH
`define RRIO_PARAMS_SVH

// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define RRIO_CTRL_OFS      8'h00
`define RRIO_CMD_OFS       8'h04
`define RRIO_STATUS_OFS    8'h08
`define RRIO_IRQ_STAT_OFS  8'h0c
`define RRIO_IRQ_MASK_OFS  8'h10
`define RRIO_LINES_OFS     8'h14
`define RRIO_MAP_BASE      8'h40

// ---------------------------------------------------------------
// fields
// ---------------------------------------------------------------
`define RRIO_CTRL_MODE_LSB   0
`define RRIO_CTRL_SERVO_BIT  4
`define RRIO_CMD_ERR_BIT     0
`define RRIO_CMD_END_BIT     1
`define RRIO_MAP_IN_LSB      0
`define RRIO_MAP_OUT_LSB     8
`define RRIO_IRQ_START       0
`define RRIO_IRQ_WAIT        1
`define RRIO_IRQ_ERROR       2
`define RRIO_IRQ_CYCLE_DONE  3
`define RRIO_IRQ_PRG_RESET   4

// ---------------------------------------------------------------
// sizes, resets, timing
// ---------------------------------------------------------------
`define RRIO_LINES       32
`define RRIO_NFUNC       12
`define RRIO_FIRST_IN    4
`define RRIO_NIRQ        5
`define RRIO_CTRL_RESET  32'h0000_0000
`define RRIO_CLK_HZ      10000000
`define RRIO_READY_US    100
`define RRIO_READY_CYC   ((`RRIO_READY_US * (`RRIO_CLK_HZ / 1000000)) < 1 ? 1 : \
                          (`RRIO_READY_US * (`RRIO_CLK_HZ / 1000000)))

`endif

// *** rrio_pkg.sv ***
// types for the remote dedicated i/o block
package rrio_pkg;

  typedef enum logic [1:0] {
    RRIO_MODE_TEACH  = 2'b00,
    RRIO_MODE_AUTO   = 2'b01,
    RRIO_MODE_REMOTE = 2'b10
  } rrio_mode_e;

  typedef enum logic [1:0] {
    RRIO_ST_IDLE = 2'b00,
    RRIO_ST_RUN  = 2'b01,
    RRIO_ST_WAIT = 2'b10
  } rrio_state_e;

  // function slots: 0..3 output only, 4..11 input with an output
  typedef enum logic [3:0] {
    RRIO_F_TEACH  = 4'h0,
    RRIO_F_AUTO   = 4'h1,
    RRIO_F_REMOTE = 4'h2,
    RRIO_F_READY  = 4'h3,
    RRIO_F_STOP   = 4'h4,
    RRIO_F_ALLOW  = 4'h5,
    RRIO_F_START  = 4'h6,
    RRIO_F_HALT2  = 4'h7,
    RRIO_F_PRGRST = 4'h8,
    RRIO_F_FLTCLR = 4'h9,
    RRIO_F_CYCLE  = 4'ha,
    RRIO_F_SERVO_DISABLE_REQ = 4'hb
  } rrio_func_e;

endpackage

// *** rrio_in_stage.sv ***
// one dedicated input: line select, level and rising-edge detect
`timescale 1ns/1ps
module rrio_in_stage (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [31:0] lines,
  input wire logic [4:0] sel,
  output logic level,
  output logic rise
);

  logic act_reg;
  logic act_next;
  logic prev_reg;
  logic prev_next;

  always_comb begin
    act_next = lines[sel];
    prev_next = act_reg;
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      act_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      act_reg <= act_next;
      prev_reg <= prev_next;
    end
  end

  // level while held, edge only on inactive-to-active
  assign level = act_reg;
  assign rise = act_reg & ~prev_reg;

endmodule

// *** rrio_plc_model.sv ***
// far-side sequencer model driving the dedicated input lines
`timescale 1ns/1ps
module rrio_plc_model (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ready,
  input wire logic slow,
  input wire logic [31:0] want,
  output logic [31:0] din
);
  // ----------------------------------------
  // request pipe, one or two cycles deep
  // ----------------------------------------
  logic [31:0] stage_reg, stage_next, out_reg, out_next;
  always_comb begin
    // nothing asserted before power-on complete; levels held, starts as edges
    stage_next = ready ? want : 32'h0;
    out_next = slow ? stage_reg : stage_next;
  end
  always_ff @(posedge ref_clk) begin
    stage_reg <= nrst ? stage_next : 32'h0;
    out_reg <= nrst ? out_next : 32'h0;
  end
  // stop lines are process signals only, never a safety stop
  assign din = out_reg;
endmodule

// *** rrio_core_props.sv ***
// port checker for the remote dedicated i/o block
`timescale 1ns/1ps
module rrio_core_props (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [31:0] din,
  input wire logic [31:0] dout,
  input wire logic servo_power
);
  // ----------------------------------------
  // cycles since reset release
  // ----------------------------------------
  logic [10:0] age_reg, age_next;
  always_comb begin
    age_next = (age_reg == 11'h7ff) ? age_reg : age_reg + 11'h001;
  end
  always_ff @(posedge ref_clk) begin
    age_reg <= nrst ? age_next : 11'h000;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence allow_held;
    ($stable(din[1]) && dout[3]) [*4];
  endsequence
  sequence servo_req_held;
    ($stable(din[7]) && dout[3]) [*4];
  endsequence
  a_ack_one_late: assert property ($rose(wb_cyc_i & wb_stb_i) |=> wb_ack_o)
    else $error("ack not one cycle after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_reset_quiet: assert property (disable iff (1'b0) !nrst |=> dout == 32'h0 && !servo_power && wb_dat_o == 32'h0)
    else $error("outputs not cleared by reset");
  a_early_silent: assert property (age_reg < 11'h3de |-> dout == 32'h0)
    else $error("status output before power-on complete");
  a_ready_by: assert property (age_reg > 11'h3f2 |-> dout[3])
    else $error("power-on complete missing");
  a_mode_onehot: assert property (dout[3] && $past(dout[3]) |-> $onehot(dout[2:0]))
    else $error("mode flags not one-hot");
  a_allow_echo: assert property (allow_held |-> dout[5] == din[1])
    else $error("auto enabled does not follow allow");
  a_servo_echo: assert property (servo_req_held |-> dout[11] == !din[7])
    else $error("servo echo wrong");
  a_servo_cut: assert property (din[7] [*4] |-> !servo_power)
    else $error("servo on while disabled");
  a_stop_halts: assert property (din[0] [*4] |-> !dout[6])
    else $error("running while stop held");
  a_wait_pair: assert property (dout[4] == dout[7])
    else $error("wait outputs differ");
endmodule
bind rrio_core rrio_core_props rrio_core_props_inst (.ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .din(din), .dout(dout),
  .servo_power(servo_power));

// *** robot_remote_dedicated_io_test.sv ***
// self-checking bench for the remote dedicated i/o block
`timescale 1ns/1ps
`include "rrio_params.svh"
module robot_remote_dedicated_io_test;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, slow = 1'b0, a;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [3:0] sel_v = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, want = 32'h0, wb_dat_o, din, dout, rd;
  logic wb_ack_o, servo_power, irq;
  int n_errors = 0, comparisons = 0, seed = 95, t0 = 0;
  always #50 ref_clk = ~ref_clk;
  rrio_core rrio_core_inst (.ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .din(din), .dout(dout), .servo_power(servo_power), .irq(irq));
  rrio_plc_model rrio_plc_model_inst (.ref_clk(ref_clk), .nrst(nrst), .ready(dout[3]), .slow(slow),
    .want(want), .din(din));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] bit_at(input int i);
    return 32'h1 << i;
  endfunction
  function automatic logic [31:0] map_word(input logic [4:0] i, input logic [4:0] o);
    return {19'h0, o, 3'h0, i};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] d);
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel_v;
    wb_dat_i <= d;
    @(posedge ref_clk);
    // no assumed latency: only the watchdog ends a hung wait
    while (wb_ack_o !== 1'b1) begin
      @(posedge ref_clk);
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic set_line(input int i, input logic v);
    want[i] <= v;
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    bus(1'b0, `RRIO_CTRL_OFS, 32'h0);
    chk(rd, `RRIO_CTRL_RESET);
    wb_adr_i <= 8'h18 + 8'(4 * ($unsigned($random(seed)) % 10));
    @(posedge ref_clk);
    bus(1'b1, wb_adr_i, 32'hffff_ffff);
    bus(1'b0, wb_adr_i, 32'h0);
    chk(rd, 32'h0);
    chk(dout, 32'h0);
    while (dout[3] !== 1'b1 && t0 < 1100) begin
      @(posedge ref_clk);
      t0++;
    end
    chk(32'(t0 > 960 && t0 < 1010), 32'h1);
    for (int m = 0; m < 3; m++) begin
      bus(1'b1, `RRIO_CTRL_OFS, 32'h10 | m);
      chk({29'h0, dout[2:0]}, bit_at(m));
    end
    chk({30'h0, servo_power, dout[11]}, 32'h3);
    // control write without lane 0 must be ignored
    sel_v = 4'h2;
    bus(1'b1, `RRIO_CTRL_OFS, 32'h0);
    sel_v = 4'hf;
    bus(1'b0, `RRIO_CTRL_OFS, 32'h0);
    chk(rd, 32'h12);
    for (int k = 0; k < 4; k++) begin
      a = 1'($random(seed));
      slow <= k[0];
      set_line(1, a);
      chk({31'h0, dout[5]}, {31'h0, a});
    end
    set_line(1, 1'b1);
    bus(1'b1, `RRIO_IRQ_MASK_OFS, 32'h1f);
    set_line(2, 1'b1);
    chk(dout & 32'h7d0, bit_at(6));
    chk({31'h0, irq}, 32'h1);
    bus(1'b0, `RRIO_STATUS_OFS, 32'h0);
    chk(rd & 32'h3, 32'h1);
    bus(1'b1, `RRIO_IRQ_STAT_OFS, 32'h1f);
    chk({31'h0, irq}, 32'h0);
    set_line(0, 1'b1);
    chk(dout & 32'h7d0, 32'h90);
    set_line(0, 1'b0);
    chk(dout & 32'h7d0, 32'h90);
    set_line(4, 1'b1);
    chk(dout & 32'h7d0, bit_at(8));
    set_line(4, 1'b0);
    set_line(2, 1'b0);
    bus(1'b1, 8'h5c, map_word(5'h14, 5'h07));
    bus(1'b0, 8'h5c, 32'h0);
    chk(rd, map_word(5'h14, 5'h07));
    set_line(2, 1'b1);
    set_line(3, 1'b1);
    chk(dout & 32'h40, 32'h40);
    set_line(20, 1'b1);
    chk(dout & 32'h7d0, 32'h90);
    set_line(20, 1'b0);
    set_line(4, 1'b1);
    set_line(4, 1'b0);
    set_line(2, 1'b0);
    bus(1'b1, `RRIO_IRQ_STAT_OFS, 32'h1f);
    bus(1'b1, `RRIO_IRQ_MASK_OFS, 32'h0);
    bus(1'b1, `RRIO_CMD_OFS, 32'h1);
    chk({dout[9], irq}, 2'b10);
    bus(1'b1, `RRIO_IRQ_MASK_OFS, 32'h4);
    chk({31'h0, irq}, 32'h1);
    set_line(5, 1'b1);
    chk({31'h0, dout[9]}, 32'h0);
    bus(1'b1, `RRIO_IRQ_STAT_OFS, 32'h1f);
    set_line(2, 1'b1);
    set_line(6, 1'b1);
    chk(dout & 32'h440, 32'h440);
    bus(1'b1, `RRIO_CMD_OFS, 32'h2);
    chk(dout & 32'h440, 32'h0);
    bus(1'b0, `RRIO_IRQ_STAT_OFS, 32'h0);
    chk(rd, 32'h9);
    set_line(7, 1'b1);
    chk({30'h0, servo_power, dout[11]}, 32'h0);
    bus(1'b0, `RRIO_LINES_OFS, 32'h0);
    chk(rd, want);
    print_verdict();
  end
  initial begin
    repeat (8000) @(posedge ref_clk);
    n_errors++;
    print_verdict();
  end
endmodule
